//--- pkg/mode_cmd_regs.svh
`ifndef MODE_CMD_REGS_SVH
`define MODE_CMD_REGS_SVH

// Register address of the operating state control register (frame bits 13-9)
`define OPSTATE_OFFSET 5'h0e
`define OPSTATE_ADDR 5'b0_1110

// Frame bits 15-14
`define PREFIX_READ_CODE 2'b00
`define PREFIX_WRITE 2'b01
`define PREFIX_READ_STATUS 2'b11

// Response bits 7-3; MODE_SLEEP_OFF_BASE matches write-frame bits 7-5
`define MODE_INIT 5'h00
`define MODE_REPROGRAM 5'h01
`define MODE_NORMAL_REQ 5'h02
`define MODE_NORMAL 5'h03
`define MODE_LP_BIT 4
`define MODE_SLEEP_OFF_BASE 3'b011

// Low byte of a global command beyond bit 7
`define GLOBAL_LOW_BITS 7'h00

// Frame length in bits
`define FRAME_BITS 5'd16
`define FRAME_HALF 5'd8

// Reset values
`define LFSR_SEED 8'h5a
`define PROTECT_RESET 1'b0
`define SAFE_RESET 1'b1
`define DEBUG_RESET 1'b0

`endif

//--- pkg/mode_cmd_pkg.sv
`default_nettype none
package mode_cmd_pkg;

   typedef struct packed {
      logic sclk;
      logic cs_n;
      logic mosi;
   } spi_in_type;

   typedef struct packed {
      logic sclk_q;
      logic cs_n_q;
      logic [4:0] bit_cnt;
      logic [15:0] rx;
      logic [15:0] tx;
      logic miso;
      logic [7:0] lfsr;
      logic [2:0] code_sent;
      logic [2:0] code_ref;
      logic code_valid;
      logic protect;
      logic [4:0] mode;
      logic safe_on;
      logic debug_on;
      logic sleep_supply_off;
      logic forced_wakeup;
      logic cyclic_sense;
      logic cyclic_int;
      logic lp_watchdog;
   } state_type;

endpackage
`default_nettype wire

//--- logic/mode_global_command_decoder.sv
`timescale 1ns/1ps
`default_nettype none
`include "mode_cmd_regs.svh"

//////////////////////////////////////////////////////////////////////////////

// Behaviour
// - The protected low-power entry is enabled only by the select input sampled while in the initialization state.
// - In normal state the read commands 0x1D00 and 0x1D80 return the three random code bits in response bits 2-0.
// - Without protection the command 0x5C60 enters supply-off sleep with cyclic sensing and forced wake-up off.
// - With protection the supply-off sleep request is 0101 1100 0110 0 followed by the inverted code bits.
// - Command 0x1D00 reports the mode, leaves debug, keeps the fail-safe output and returns the random code.
// - Command 0x1D80 reports the mode and random code and turns the fail-safe output off.
// - Command 0xDD00 reports the mode, leaves debug, keeps fail-safe and returns fail-safe in bit 1 and debug in bit 0.
// - Command 0xDD80 reports the mode, keeps debug, turns fail-safe off, with fail-safe in bit 1 and debug in bit 0.
// - Response bits 7-3 always carry the current state code, with bit 7 set for any low-power state.
// - Response fail-safe bit reads 1 while the fail-safe driver is active and 0 while it is off.
// - Response debug bit reads 1 while debug is active and 0 when it is off.
module mode_global_command_decoder
(
   input wire logic clock,
   input wire logic reset,
   input wire logic clock_enable,
   input wire mode_cmd_pkg::spi_in_type spi_in,
   input wire logic [7:0] fix_status,
   input wire logic protect_select,
   input wire logic advance_normal,
   input wire logic wake_event,
   input wire logic safe_activate,
   input wire logic debug_enter,
   output logic spi_miso,
   output logic [4:0] mode_code,
   output logic safe_out,
   output logic debug_active,
   output logic sleep_supply_off,
   output logic forced_wakeup,
   output logic cyclic_sense,
   output logic cyclic_int,
   output logic lp_watchdog
);
   import mode_cmd_pkg::*;

   state_type s_q;
   state_type s_d;

   //////////////////////////////////////////////////////////////////////////////

   always_comb
   begin
      logic cs_fall;
      logic cs_rise;
      logic sclk_rise;
      logic sclk_fall;
      logic [15:0] tx_next;
      logic [15:0] cmd;
      logic is_global;
      logic mode_write;
      logic code_ok;
      cs_fall = 1'b0;
      cs_rise = 1'b0;
      sclk_rise = 1'b0;
      sclk_fall = 1'b0;
      tx_next = 16'h0000;
      cmd = 16'h0000;
      is_global = 1'b0;
      mode_write = 1'b0;
      code_ok = 1'b0;
      s_d = s_q;

      s_d.sclk_q = spi_in.sclk;
      s_d.cs_n_q = spi_in.cs_n;
      cs_fall = s_q.cs_n_q & ~spi_in.cs_n;
      cs_rise = ~s_q.cs_n_q & spi_in.cs_n;
      sclk_rise = ~spi_in.cs_n & ~s_q.sclk_q & spi_in.sclk;
      sclk_fall = ~spi_in.cs_n & s_q.sclk_q & ~spi_in.sclk;

      // Free-running code source; the host cannot predict its phase
      s_d.lfsr = {s_q.lfsr[6:0], s_q.lfsr[7] ^ s_q.lfsr[5] ^ s_q.lfsr[4] ^ s_q.lfsr[3]};

      if (s_q.mode == `MODE_INIT)
      begin
         s_d.protect = protect_select;
      end

      if (advance_normal && (s_q.mode == `MODE_INIT || s_q.mode == `MODE_NORMAL_REQ))
      begin
         s_d.mode = `MODE_NORMAL;
      end
      if (wake_event && s_q.mode[`MODE_LP_BIT])
      begin
         s_d.mode = `MODE_NORMAL_REQ;
         s_d.sleep_supply_off = 1'b0;
         s_d.forced_wakeup = 1'b0;
         s_d.cyclic_sense = 1'b0;
         s_d.cyclic_int = 1'b0;
         s_d.lp_watchdog = 1'b0;
      end

      //////////////////////////////////////////////////////////////////////////////

      if (cs_fall)
      begin
         // state code in bits 7-3; code preloaded in bits 2-0
         s_d.tx = {fix_status, s_q.mode, s_q.lfsr[2:0]};
         s_d.code_sent = s_q.lfsr[2:0];
         s_d.miso = fix_status[7];
         s_d.bit_cnt = 5'd0;
      end

      if (sclk_rise)
      begin
         s_d.rx = {s_q.rx[14:0], spi_in.mosi};
         if (s_q.bit_cnt != 5'd31)
         begin
            s_d.bit_cnt = s_q.bit_cnt + 5'd1;
         end
      end

      if (sclk_fall)
      begin
         tx_next = {s_q.tx[14:0], 1'b0};
         // Bits 15-14 are known after the first byte, in time to patch bits 2-0
         if (s_q.bit_cnt == `FRAME_HALF && s_q.rx[7:6] == `PREFIX_READ_STATUS)
         begin
            tx_next[10:8] = {1'b0, s_q.safe_on, s_q.debug_on};
         end
         s_d.tx = tx_next;
         s_d.miso = s_q.tx[14];
      end

      //////////////////////////////////////////////////////////////////////////////

      if (cs_rise && s_q.bit_cnt == `FRAME_BITS)
      begin
         cmd = s_q.rx;
         // global form needs bit 8 set and a clear low part
         is_global = (cmd[13:9] == `OPSTATE_ADDR) && cmd[8] && (cmd[6:0] == `GLOBAL_LOW_BITS)
            && (cmd[15:14] == `PREFIX_READ_CODE || cmd[15:14] == `PREFIX_READ_STATUS);
         mode_write = (cmd[15:14] == `PREFIX_WRITE) && (cmd[13:9] == `OPSTATE_ADDR);
         if (is_global)
         begin
            // leave debug on bit 7 clear; same for the status form
            if (!cmd[7])
            begin
               s_d.debug_on = 1'b0;
            end
            else
            begin
               s_d.safe_on = 1'b0;
            end
            // remember the code the host has now seen
            if (cmd[15:14] == `PREFIX_READ_CODE)
            begin
               s_d.code_ref = s_q.code_sent;
               s_d.code_valid = 1'b1;
            end
         end
         // protected entry only with the inverted code from the last 0x1D00/0x1D80 reply
         code_ok = !s_q.protect || (s_q.code_valid && cmd[2:0] == ~s_q.code_ref);
         if (mode_write && s_q.mode == `MODE_NORMAL && code_ok)
         begin
            // supply-off sleep, features from bits 4-3; same with code check
            if (cmd[7:5] == `MODE_SLEEP_OFF_BASE)
            begin
               s_d.mode = {1'b1, 2'b00, cmd[4:3]};
               s_d.sleep_supply_off = 1'b1;
               s_d.forced_wakeup = cmd[4];
               s_d.cyclic_sense = cmd[3];
               s_d.code_valid = 1'b0;
            end
            else if (cmd[7])
            begin
               s_d.mode = cmd[7:3];
               s_d.forced_wakeup = cmd[6];
               s_d.cyclic_sense = cmd[5];
               s_d.cyclic_int = cmd[4];
               s_d.lp_watchdog = cmd[3];
               s_d.code_valid = 1'b0;
            end
         end
      end

      // set wins
      // A fault raised in the cycle of a release frame must not be lost
      if (safe_activate)
      begin
         s_d.safe_on = 1'b1;
      end
      if (debug_enter)
      begin
         s_d.debug_on = 1'b1;
      end
   end

   //////////////////////////////////////////////////////////////////////////////

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         s_q <= '0;
         s_q.sclk_q <= 1'b0;
         s_q.cs_n_q <= 1'b1;
         s_q.lfsr <= `LFSR_SEED;
         s_q.protect <= `PROTECT_RESET;
         s_q.mode <= `MODE_INIT;
         s_q.safe_on <= `SAFE_RESET;
         s_q.debug_on <= `DEBUG_RESET;
      end
      else if (clock_enable)
      begin
         s_q <= s_d;
      end
   end

   assign spi_miso = s_q.miso;
   assign mode_code = s_q.mode;
   assign safe_out = s_q.safe_on;
   assign debug_active = s_q.debug_on;
   assign sleep_supply_off = s_q.sleep_supply_off;
   assign forced_wakeup = s_q.forced_wakeup;
   assign cyclic_sense = s_q.cyclic_sense;
   assign cyclic_int = s_q.cyclic_int;
   assign lp_watchdog = s_q.lp_watchdog;

endmodule

`default_nettype wire

//--- tb/mode_cmd_checker.sv
`timescale 1ns/1ps
`default_nettype none
module mode_cmd_checker
(
   input wire logic clock,
   input wire logic reset,
   input wire logic clock_enable,
   input wire mode_cmd_pkg::spi_in_type spi_in,
   input wire logic advance_normal,
   input wire logic wake_event,
   input wire logic safe_activate,
   input wire logic debug_enter,
   input wire logic [4:0] mode_code,
   input wire logic safe_out,
   input wire logic debug_active,
   input wire logic sleep_supply_off
);
   import mode_cmd_pkg::*;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);
   // Frames act on a cs_n rise, so the hold, wake and advance checks judge only quiet stretches
   sequence idle;
      spi_in.cs_n[*4] ##0 clock_enable;
   endsequence
   a_reset_values: assert property (disable iff (1'b0) reset |=> safe_out && !debug_active && mode_code == 5'h00)
      else $error("reset values wrong");
   a_safe_set: assert property (clock_enable && safe_activate |=> safe_out)
      else $error("fail-safe output not set");
   a_debug_set: assert property (clock_enable && debug_enter |=> debug_active)
      else $error("debug state not set");
   a_safe_hold: assert property (idle ##0 !safe_out && !safe_activate |=> !safe_out)
      else $error("fail-safe output rose without cause");
   a_mode_quiet: assert property (idle ##0 !advance_normal && !wake_event |=> $stable(mode_code))
      else $error("mode changed without cause");
   a_lp_code: assert property (sleep_supply_off |-> mode_code[4])
      else $error("sleep without low-power code");
   a_wake_exit: assert property (idle ##0 wake_event && mode_code[4] |=> mode_code == 5'h02 && !sleep_supply_off)
      else $error("wake did not reach normal request");
   a_init_advance: assert property (idle ##0 advance_normal && mode_code == 5'h00 |=> mode_code == 5'h03)
      else $error("init did not reach normal");
   a_frozen_state: assert property (!clock_enable |=> $stable(mode_code) && $stable(safe_out) && $stable(debug_active))
      else $error("state moved while clock enable low");
endmodule
bind mode_global_command_decoder mode_cmd_checker chk (.clock, .reset, .clock_enable, .spi_in, .advance_normal,
   .wake_event, .safe_activate, .debug_enter, .mode_code, .safe_out, .debug_active, .sleep_supply_off);
`default_nettype wire

//--- tb/spi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module spi_host_model
(
   input wire logic clock,
   input wire logic miso,
   output var mode_cmd_pkg::spi_in_type spi
);
   import mode_cmd_pkg::*;
   initial spi = '{sclk: 1'b0, cs_n: 1'b1, mosi: 1'b0};
   task automatic wait_n(input int n);
      repeat (n) @(negedge clock);
   endtask
   task automatic xfer(input logic [15:0] cmd, output logic [15:0] resp);
      spi.cs_n = 1'b0;
      for (int i = 15; i >= 0; i--)
      begin
         spi.mosi = cmd[i];
         wait_n(3);
         resp[i] = miso;
         spi.sclk = 1'b1;
         wait_n(3);
         spi.sclk = 1'b0;
      end
      // Mosi flips before cs_n is released so a stale bit is never mistaken for data
      spi.mosi = ~spi.mosi;
      wait_n(2);
      spi.cs_n = 1'b1;
      wait_n(4);
   endtask
endmodule
`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import mode_cmd_pkg::*;
   logic clock = 1'b0, reset = 1'b1, protect_select = 1'b0, advance_normal = 1'b0;
   logic wake_event = 1'b0, safe_activate = 1'b0, debug_enter = 1'b0, clock_enable = 1'b1;
   logic spi_miso, safe_out, debug_active, sleep_supply_off, forced_wakeup, cyclic_sense, cyclic_int, lp_watchdog;
   logic [4:0] mode_code;
   logic [15:0] r;
   logic [2:0] c;
   spi_in_type spi_in;
   int n_mismatch = 0, check_count = 0, cycles = 0;
   initial forever #20 clock = ~clock;
   spi_host_model host (.clock(clock), .miso(spi_miso), .spi(spi_in));
   mode_global_command_decoder dut (.clock(clock), .reset(reset), .clock_enable(clock_enable), .spi_in(spi_in),
      .fix_status(8'hc3), .protect_select(protect_select), .advance_normal(advance_normal),
      .wake_event(wake_event), .safe_activate(safe_activate), .debug_enter(debug_enter), .spi_miso(spi_miso),
      .mode_code(mode_code), .safe_out(safe_out), .debug_active(debug_active),
      .sleep_supply_off(sleep_supply_off), .forced_wakeup(forced_wakeup), .cyclic_sense(cyclic_sense),
      .cyclic_int(cyclic_int), .lp_watchdog(lp_watchdog));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [15:0] exp, got);
      check_count++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   function automatic logic [15:0] st();
      return {9'h000, mode_code, safe_out, debug_active};
   endfunction
   task automatic pulse(ref logic s);
      s = 1'b1;
      @(negedge clock);
      s = 1'b0;
      @(negedge clock);
   endtask
   task automatic do_reset(input logic prot);
      reset = 1'b1;
      protect_select = prot;
      repeat (5) @(negedge clock);
      reset = 1'b0;
      @(negedge clock);
      chk("reset state", 16'h0002, st());
      // Quiet INIT stretch so the checker sees a clean advance
      repeat (4) @(negedge clock);
      pulse(advance_normal);
      // Late change of the select must not alter the latched choice
      protect_select = ~prot;
      chk("normal state", 16'h000e, st());
   endtask
   task automatic t_status();
      pulse(debug_enter);
      host.xfer(16'hdd80, r);
      chk("dd80 reply", 16'hc31b, r & 16'hfffb);
      chk("after dd80", 16'h000d, st());
      host.xfer(16'hdd00, r);
      chk("dd00 reply", 16'hc319, r & 16'hfffb);
      chk("after dd00", 16'h000c, st());
   endtask
   task automatic t_code();
      clock_enable = 1'b0;
      pulse(safe_activate);
      clock_enable = 1'b1;
      chk("frozen", 16'h000c, st());
      pulse(safe_activate);
      pulse(debug_enter);
      host.xfer(16'h1d00, r);
      chk("1d00 reply", 16'hc318, r & 16'hfff8);
      chk("after 1d00", 16'h000e, st());
      host.xfer(16'h1d80, r);
      chk("1d80 reply", 16'hc318, r & 16'hfff8);
      chk("after 1d80", 16'h000c, st());
   endtask
   task automatic t_sleep(input logic prot);
      host.xfer(16'h1d00, r);
      c = r[2:0];
      host.xfer(16'he100, r);
      chk("flag clear ignored", 16'h0003, {11'h000, mode_code});
      if (prot)
      begin
         host.xfer({13'h0b8c, c}, r);
         chk("bad code ignored", 16'h0003, {11'h000, mode_code});
      end
      host.xfer({13'h0b8c, prot ? ~c : 3'b000}, r);
      chk("sleep entered", 16'h0030, {10'h000, mode_code[4], sleep_supply_off, forced_wakeup, cyclic_sense,
         cyclic_int, lp_watchdog});
      pulse(wake_event);
      chk("woken", 16'h0040, {6'h00, mode_code, sleep_supply_off, forced_wakeup, cyclic_sense, cyclic_int,
         lp_watchdog});
      pulse(advance_normal);
      if (!prot)
      begin
         host.xfer(16'h5cf8, r);
         chk("low-power entered", 16'h002f, {10'h000, mode_code[4], sleep_supply_off, forced_wakeup, cyclic_sense,
            cyclic_int, lp_watchdog});
         pulse(wake_event);
         chk("woken again", 16'h0040, {6'h00, mode_code, sleep_supply_off, forced_wakeup, cyclic_sense, cyclic_int,
            lp_watchdog});
         pulse(advance_normal);
      end
   endtask
   task give_verdict();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_mismatch++;
         give_verdict();
      end
   end
   initial
   begin
      do_reset(1'b1);
      t_status();
      t_code();
      t_sleep(1'b1);
      do_reset(1'b0);
      t_sleep(1'b0);
      give_verdict();
   end
endmodule
`default_nettype wire
